//--- timer_pkg.sv
package timer_pkg;

    // ------------------------------------------------------------------
    // counter and compare values
    // ------------------------------------------------------------------
    localparam logic [15:0] COUNT_PRESET = 16'hFFFC;
    localparam logic [15:0] COUNT_RESET_VALUE = 16'hFFFC;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COMPARE_RESET = 16'h8000;
    localparam logic [15:0] CAPTURE_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // timer clock select encodings and prescaler masks
    // ------------------------------------------------------------------
    localparam logic [1:0] CLKSEL_DIV4 = 2'h0;
    localparam logic [1:0] CLKSEL_DIV2 = 2'h1;
    localparam logic [1:0] CLKSEL_DIV8 = 2'h2;
    localparam logic [1:0] CLKSEL_EXT = 2'h3;
    localparam logic [2:0] DIV2_MASK = 3'h1;
    localparam logic [2:0] DIV4_MASK = 3'h3;
    localparam logic [2:0] DIV8_MASK = 3'h7;

    // ------------------------------------------------------------------
    // event flag positions
    // ------------------------------------------------------------------
    localparam int FLAG_CAP1 = 0;
    localparam int FLAG_CAP2 = 1;
    localparam int FLAG_CMP1 = 2;
    localparam int FLAG_CMP2 = 3;
    localparam int FLAG_OVF = 4;
    localparam int FLAG_COUNT = 5;

    // operating mode, gray ordered
    typedef enum logic [1:0] {
        MODE_COMPARE = 2'h0,
        MODE_ONE_PULSE = 2'h1,
        MODE_PWM = 2'h3
    } mode_t;

    // active transition on a synchronised input
    function automatic logic edge_seen(input logic cur, input logic prev, input logic rising);
        edge_seen = rising ? (cur & ~prev) : (~cur & prev);
    endfunction : edge_seen

endpackage : timer_pkg

//--- timer_pulse_pwm.sv
`timescale 1ns/1ps
module timer_pulse_pwm
    import timer_pkg::*;
#(
    parameter int PRESCALE_WIDTH = 3
) (
    input wire logic mclk, // cpu clock
    input wire logic rst_b, // async reset, active low
    input wire logic capture_one_pin, // trigger / capture input one
    input wire logic capture_two_pin, // capture input two
    input wire logic ext_clk_pin, // external timer clock
    input wire logic [1:0] timer_clock_select, // timer clock source
    input wire logic capture_one_edge_select, // 1 rising, 0 falling
    input wire logic capture_two_edge_select, // 1 rising, 0 falling
    input wire logic one_pulse_select, // one-pulse mode
    input wire logic pwm_select, // pwm mode
    input wire logic after_pulse_level, // level after pulse / first match
    input wire logic during_pulse_level, // level during pulse / second match
    input wire logic compare_one_pin_enable, // route waveform to pin
    input wire logic capture_irq_enable, // capture interrupt enable
    input wire logic compare_irq_enable, // compare interrupt enable
    input wire logic overflow_irq_enable, // overflow interrupt enable
    input wire logic global_mask, // cpu interrupt mask
    input wire logic [7:0] write_data, // byte written by software
    input wire logic compare_one_high_write, // write pulse
    input wire logic compare_one_low_write, // write pulse
    input wire logic compare_two_high_write, // write pulse
    input wire logic compare_two_low_write, // write pulse
    input wire logic status_read, // status register read pulse
    input wire logic capture_one_low_access, // capture one low byte access
    input wire logic capture_two_low_access, // capture two low byte access
    input wire logic counter_low_access, // counter low byte access
    input wire logic wait_state, // cpu in wait
    input wire logic halt_state, // cpu in halt
    input wire logic halt_wake_irq, // pulse: halt left by interrupt
    output logic [15:0] counter_value, // free running counter
    output logic [15:0] capture_one_value, // capture register one
    output logic [15:0] capture_two_value, // capture register two
    output logic [15:0] compare_one_value, // compare register one
    output logic [15:0] compare_two_value, // compare register two
    output logic capture_one_flag, // event flag
    output logic capture_two_flag, // event flag
    output logic compare_one_flag, // event flag
    output logic compare_two_flag, // event flag
    output logic overflow_flag, // event flag
    output logic compare_one_pin, // waveform level
    output logic compare_one_pin_oe, // pin driven by timer
    output logic timer_irq, // shared timer interrupt
    output logic wait_wake // wake request from wait
);

    initial begin
        if (PRESCALE_WIDTH < 3) begin
            $error("prescaler too narrow for divide by eight");
        end
    end

    // ------------------------------------------------------------------
    // input synchronisers and prescaler
    // ------------------------------------------------------------------
    logic [2:0] pin_meta, pin_sync, pin_prev;
    logic [PRESCALE_WIDTH-1:0] prescale, next_prescale;
    logic tick;
    logic cap1_edge, cap2_edge;
    mode_t mode;

    // edge detection on second stage only, prescaler stops in halt
    always_comb begin
        cap1_edge = edge_seen(pin_sync[0], pin_prev[0], capture_one_edge_select);
        cap2_edge = edge_seen(pin_sync[1], pin_prev[1], capture_two_edge_select);
        next_prescale = halt_state ? prescale : prescale + 1'b1;
        unique case (timer_clock_select)
            CLKSEL_DIV2: tick = (prescale[2:0] & DIV2_MASK) == DIV2_MASK;
            CLKSEL_DIV4: tick = (prescale[2:0] & DIV4_MASK) == DIV4_MASK;
            CLKSEL_DIV8: tick = (prescale[2:0] & DIV8_MASK) == DIV8_MASK;
            CLKSEL_EXT: tick = pin_sync[2] & ~pin_prev[2];
        endcase
        if (pwm_select) begin
            mode = MODE_PWM;
        end else if (one_pulse_select) begin
            mode = MODE_ONE_PULSE;
        end else begin
            mode = MODE_COMPARE;
        end
    end

    // two flops per pin plus one for the edge detector
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
            pin_prev <= 3'h0;
            prescale <= '0;
        end else begin
            pin_meta <= {ext_clk_pin, capture_two_pin, capture_one_pin};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
            prescale <= next_prescale;
        end
    end

    // ------------------------------------------------------------------
    // timer core
    // ------------------------------------------------------------------
    logic [15:0] count, next_count;
    logic [15:0] cmp_reg [2];
    logic [15:0] next_cmp_reg [2];
    logic [15:0] shadow [2];
    logic [15:0] next_shadow [2];
    logic [1:0] lock, next_lock;
    logic [15:0] cap_reg [2];
    logic [15:0] next_cap_reg [2];
    logic [1:0] halt_armed, next_halt_armed;
    logic [FLAG_COUNT-1:0] flags, next_flags;
    logic [FLAG_COUNT-1:0] clear_armed, next_clear_armed;
    logic [FLAG_COUNT-1:0] events;
    logic [FLAG_COUNT-1:0] access;
    logic pin, next_pin;
    logic pin_oe;
    logic irq, next_irq;
    logic wake, next_wake;
    logic run, trigger;
    logic [1:0] match;
    logic [1:0] hi_wr, lo_wr;

    always_comb begin
        hi_wr = {compare_two_high_write, compare_one_high_write};
        lo_wr = {compare_two_low_write, compare_one_low_write};
        access = {counter_low_access, lo_wr, capture_two_low_access, capture_one_low_access};
        run = tick & ~halt_state;
        trigger = (mode == MODE_ONE_PULSE) & cap1_edge & ~halt_state;
        next_count = count;
        next_pin = pin;
        next_halt_armed = halt_armed;
        events = '0;
        for (int i = 0; i < 2; i++) begin
            // compare value counts only when unlocked, except in pwm
            match[i] = run && count == shadow[i] && (mode == MODE_PWM || !lock[i]);
            next_cmp_reg[i] = cmp_reg[i];
            next_lock[i] = lock[i];
            next_cap_reg[i] = cap_reg[i];
            if (hi_wr[i]) begin
                next_cmp_reg[i][15:8] = write_data;
                next_lock[i] = 1'b1;
            end
            if (lo_wr[i]) begin
                next_cmp_reg[i][7:0] = write_data;
                next_lock[i] = 1'b0;
            end
        end
        // shadows follow at once outside pwm, at period end in pwm
        for (int i = 0; i < 2; i++) begin
            next_shadow[i] = shadow[i];
            if (!lock[i] && (mode != MODE_PWM || match[1])) begin
                next_shadow[i] = cmp_reg[i];
            end
        end
        if (run) begin
            next_count = count + 16'h0001;
            events[FLAG_OVF] = count == COUNT_MAX;
        end
        // capture inputs; first input gone in pwm, trigger only in one-pulse
        if (halt_state) begin
            next_halt_armed = halt_armed | {cap2_edge, cap1_edge & (mode != MODE_PWM)};
        end else begin
            if (cap1_edge && mode != MODE_PWM) begin
                next_cap_reg[0] = count;
                events[FLAG_CAP1] = 1'b1;
            end
            if (cap2_edge) begin
                next_cap_reg[1] = count;
                events[FLAG_CAP2] = 1'b1;
            end
        end
        if (halt_wake_irq) begin
            for (int i = 0; i < 2; i++) begin
                if (halt_armed[i]) begin
                    next_cap_reg[i] = count;
                    events[i] = 1'b1;
                end
            end
            next_halt_armed = 2'h0;
        end
        unique case (mode)
            MODE_COMPARE: begin
                events[FLAG_CMP1] = match[0];
                events[FLAG_CMP2] = match[1];
                if (match[0]) begin
                    next_pin = after_pulse_level;
                end
            end
            MODE_ONE_PULSE: begin
                events[FLAG_CMP2] = match[1];
                if (trigger) begin
                    next_count = COUNT_PRESET;
                    next_pin = during_pulse_level;
                end else if (match[0]) begin
                    next_pin = after_pulse_level;
                end
            end
            MODE_PWM: begin
                if (match[1]) begin
                    next_count = COUNT_PRESET;
                    next_pin = during_pulse_level;
                    events[FLAG_CAP1] = 1'b1;
                end else if (match[0]) begin
                    next_pin = after_pulse_level;
                end
            end
        endcase
        if (mode != MODE_COMPARE && after_pulse_level == during_pulse_level) begin
            next_pin = after_pulse_level;
        end
        // status read arms the clear, the byte access finishes it, a new event wins
        next_clear_armed = (clear_armed | ({FLAG_COUNT{status_read}} & flags)) & ~access;
        next_flags = (flags & ~(clear_armed & access)) | events;
        next_irq = ~global_mask & (
            (capture_irq_enable & (flags[FLAG_CAP1] | flags[FLAG_CAP2])) |
            (compare_irq_enable & (flags[FLAG_CMP1] | flags[FLAG_CMP2])) |
            (overflow_irq_enable & flags[FLAG_OVF]));
        next_wake = next_irq & wait_state & ~halt_state;
    end

    // core registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count <= COUNT_RESET_VALUE;
            cmp_reg <= '{COMPARE_RESET, COMPARE_RESET};
            shadow <= '{COMPARE_RESET, COMPARE_RESET};
            cap_reg <= '{CAPTURE_RESET, CAPTURE_RESET};
            lock <= 2'h0;
            halt_armed <= 2'h0;
            flags <= '0;
            clear_armed <= '0;
            pin <= 1'b0;
            pin_oe <= 1'b0;
            irq <= 1'b0;
            wake <= 1'b0;
        end else begin
            count <= next_count;
            cmp_reg <= next_cmp_reg;
            shadow <= next_shadow;
            cap_reg <= next_cap_reg;
            lock <= next_lock;
            halt_armed <= next_halt_armed;
            flags <= next_flags;
            clear_armed <= next_clear_armed;
            pin <= next_pin;
            pin_oe <= compare_one_pin_enable;
            irq <= next_irq;
            wake <= next_wake;
        end
    end

    // outputs straight from flops
    assign counter_value = count;
    assign capture_one_value = cap_reg[0];
    assign capture_two_value = cap_reg[1];
    assign compare_one_value = cmp_reg[0];
    assign compare_two_value = cmp_reg[1];
    assign capture_one_flag = flags[FLAG_CAP1];
    assign capture_two_flag = flags[FLAG_CAP2];
    assign compare_one_flag = flags[FLAG_CMP1];
    assign compare_two_flag = flags[FLAG_CMP2];
    assign overflow_flag = flags[FLAG_OVF];
    assign compare_one_pin = pin;
    assign compare_one_pin_oe = pin_oe;
    assign timer_irq = irq;
    assign wait_wake = wake;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence flag_read_s;
        status_read && capture_two_flag;
    endsequence
    sequence flag_idle_s;
        !capture_two_low_access;
    endsequence
    sequence flag_access_s;
        capture_two_low_access && !cap2_edge && !halt_wake_irq;
    endsequence

    chk_opm_trigger_preset: assert property (trigger |=> count == COUNT_PRESET && pin == $past(during_pulse_level))
        else $error("one-pulse trigger did not preset counter and start pulse");
    chk_opm_pulse_end: assert property (mode == MODE_ONE_PULSE && !trigger && match[0] |=> pin == $past(after_pulse_level))
        else $error("one-pulse match did not end pulse");
    chk_opm_no_cmp1: assert property (mode == MODE_ONE_PULSE && !compare_one_flag |=> !compare_one_flag)
        else $error("first compare flag set in one-pulse mode");
    chk_pwm_no_cmp_flags: assert property (mode == MODE_PWM && !compare_one_flag && !compare_two_flag |=> !compare_one_flag && !compare_two_flag)
        else $error("compare flag set in pwm mode");
    chk_pwm_period_end: assert property (mode == MODE_PWM && match[1] |=> count == COUNT_PRESET && capture_one_flag)
        else $error("pwm period end did not preset counter or flag");
    chk_equal_level_hold: assert property (mode != MODE_COMPARE && after_pulse_level == during_pulse_level |=> pin == $past(after_pulse_level))
        else $error("pin moved with equal levels");
    chk_halt_freeze: assert property (halt_state |=> count == $past(count))
        else $error("counter moved during halt");
    chk_flag_clear: assert property (flag_read_s ##1 flag_idle_s ##1 flag_access_s |=> !capture_two_flag)
        else $error("capture flag not cleared by read then access");
    chk_irq_masked: assert property (global_mask |=> !timer_irq)
        else $error("interrupt raised while masked");
    chk_halt_wake_capture: assert property (halt_armed[1] && halt_wake_irq && !halt_state |=> capture_two_flag && capture_two_value == $past(count))
        else $error("armed halt capture not taken at wake");

endmodule : timer_pulse_pwm

//--- pulse_source.sv
`timescale 1ns/1ps
module pulse_source (
    input wire logic mclk, // cpu clock
    input wire logic compare_one_pin, // waveform from timer
    input wire logic compare_one_pin_oe, // timer drives the pin
    output logic capture_one_pin, // trigger line
    output logic capture_two_pin, // capture line
    output logic load_level // level seen by the load
);
    // load has a pull-down, so a released pin reads low
    assign load_level = compare_one_pin_oe ? compare_one_pin : 1'b0;

    initial begin
        capture_one_pin = 1'b0;
        capture_two_pin = 1'b0;
    end

    // one high pulse, each level held at least one cycle
    task automatic pulse(input int line, input int hold);
        repeat (2) begin
            @(posedge mclk);
            if (line == 1) capture_one_pin <= ~capture_one_pin;
            else capture_two_pin <= ~capture_two_pin;
            repeat (hold) @(posedge mclk);
        end
    endtask : pulse
endmodule : pulse_source

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import timer_pkg::*;
    // ------------------------------------------------------------------
    // design signals
    // ------------------------------------------------------------------
    logic mclk = 1'b0, rst_b = 1'b0, ext_clk_pin = 1'b0, status_read = 1'b0;
    logic [1:0] timer_clock_select = CLKSEL_DIV2;
    logic capture_one_edge_select = 1'b1, capture_two_edge_select = 1'b1;
    logic one_pulse_select = 1'b0, pwm_select = 1'b0, compare_one_pin_enable = 1'b1;
    logic after_pulse_level = 1'b0, during_pulse_level = 1'b1, global_mask = 1'b1;
    logic capture_irq_enable = 1'b0, compare_irq_enable = 1'b0, overflow_irq_enable = 1'b0;
    logic [7:0] write_data = 8'h00;
    logic compare_one_high_write = 1'b0, compare_one_low_write = 1'b0;
    logic compare_two_high_write = 1'b0, compare_two_low_write = 1'b0;
    logic capture_one_low_access = 1'b0, capture_two_low_access = 1'b0;
    logic counter_low_access = 1'b0, wait_state = 1'b0, halt_state = 1'b0;
    logic halt_wake_irq = 1'b0, capture_one_pin, capture_two_pin, load_level;
    logic [15:0] counter_value, capture_one_value, capture_two_value;
    logic [15:0] compare_one_value, compare_two_value, c0, cap;
    logic capture_one_flag, capture_two_flag, compare_one_flag, compare_two_flag;
    logic overflow_flag, compare_one_pin, compare_one_pin_oe, timer_irq, wait_wake;
    int fail_count = 0, n_compared = 0, cycles = 0, n, a, b, v;

    always #10 mclk = ~mclk;

    timer_pulse_pwm u_timer_pulse_pwm (.mclk, .rst_b, .capture_one_pin, .capture_two_pin,
        .ext_clk_pin, .timer_clock_select, .capture_one_edge_select, .capture_two_edge_select,
        .one_pulse_select, .pwm_select, .after_pulse_level, .during_pulse_level,
        .compare_one_pin_enable, .capture_irq_enable, .compare_irq_enable,
        .overflow_irq_enable, .global_mask, .write_data, .compare_one_high_write,
        .compare_one_low_write, .compare_two_high_write, .compare_two_low_write,
        .status_read, .capture_one_low_access, .capture_two_low_access, .counter_low_access,
        .wait_state, .halt_state, .halt_wake_irq, .counter_value, .capture_one_value,
        .capture_two_value, .compare_one_value, .compare_two_value, .capture_one_flag,
        .capture_two_flag, .compare_one_flag, .compare_two_flag, .overflow_flag,
        .compare_one_pin, .compare_one_pin_oe, .timer_irq, .wait_wake);

    pulse_source u_pulse_source (.mclk, .compare_one_pin, .compare_one_pin_oe,
        .capture_one_pin, .capture_two_pin, .load_level);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : cyc

    // one-cycle strobe: 0 status, 1/2 capture low access, 3..6 compare writes
    task automatic strobe(input int k, input logic [7:0] d);
        @(posedge mclk);
        write_data <= d;
        case (k)
            0: status_read <= 1'b1;
            1: capture_one_low_access <= 1'b1;
            2: capture_two_low_access <= 1'b1;
            3: compare_one_high_write <= 1'b1;
            4: compare_one_low_write <= 1'b1;
            5: compare_two_high_write <= 1'b1;
            default: compare_two_low_write <= 1'b1;
        endcase
        @(posedge mclk);
        {status_read, capture_one_low_access, capture_two_low_access} <= 3'h0;
        {compare_one_high_write, compare_one_low_write} <= 2'h0;
        {compare_two_high_write, compare_two_low_write} <= 2'h0;
    endtask : strobe

    // high byte first, then low byte
    task automatic wr(input int r, input logic [15:0] val);
        strobe(2 * r + 1, val[15:8]);
        strobe(2 * r + 2, val[7:0]);
        #1;
    endtask : wr

    task automatic do_reset;
        @(posedge mclk);
        rst_b <= 1'b0;
        cyc(8);
        @(posedge mclk);
        rst_b <= 1'b1;
    endtask : do_reset

    // cycles the load sees high in one pwm pulse
    task automatic high_len(output int len);
        for (n = 0; load_level !== 1'b1 && n < 600; n++) cyc(1);
        for (len = 0; load_level !== 1'b0 && len < 600; len++) cyc(1);
    endtask : high_len

    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            stop_test();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(27987));
        cyc(7);
        chk(counter_value, COUNT_RESET_VALUE);
        chk(compare_one_value, COMPARE_RESET);
        chk({capture_one_flag, compare_two_flag, overflow_flag, compare_one_pin}, 16'h0000);
        @(posedge mclk);
        rst_b <= 1'b1;
        // one-pulse: trigger, pulse length, flags
        v = 8 + $urandom_range(32);
        one_pulse_select <= 1'b1;
        wr(1, 16'(v));
        chk(compare_one_value, 16'(v));
        wr(2, 16'(v / 2));
        // watch for the trigger while the source is still busy with the pulse
        fork
            u_pulse_source.pulse(1, 3);
        join_none
        for (n = 0; capture_one_flag !== 1'b1 && n < 20; n++) cyc(1);
        chk(counter_value, COUNT_PRESET);
        chk(load_level, 1'b1);
        for (n = 0; load_level !== 1'b0 && n < 400; n++) cyc(1);
        chk(n >= 2 * v + 7 && n <= 2 * v + 11, 1'b1);
        chk({compare_one_flag, compare_two_flag}, 16'h0001);
        strobe(1, 8'h00);
        cyc(2);
        chk(capture_one_flag, 1'b1);
        strobe(0, 8'h00);
        strobe(1, 8'h00);
        cyc(2);
        chk(capture_one_flag, 1'b0);
        $display("one-pulse test done");
        // clock select in plain compare mode
        one_pulse_select <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            timer_clock_select <= (i == 0) ? CLKSEL_DIV4 : (i == 1) ? CLKSEL_DIV2 : CLKSEL_DIV8;
            cyc(3);
            c0 = counter_value;
            cyc(64);
            chk(counter_value - c0, (i == 0) ? 16'h0010 : (i == 1) ? 16'h0020 : 16'h0008);
        end
        timer_clock_select <= CLKSEL_EXT;
        cyc(3);
        c0 = counter_value;
        repeat (8) begin
            @(posedge mclk);
            ext_clk_pin <= 1'b1;
            cyc(3);
            @(posedge mclk);
            ext_clk_pin <= 1'b0;
            cyc(3);
        end
        cyc(4);
        chk(counter_value - c0, 16'h0008);
        $display("clock select test done");
        // pwm: both selects set, high time and double buffering
        timer_clock_select <= CLKSEL_DIV2;
        after_pulse_level <= 1'b1;
        during_pulse_level <= 1'b0;
        do_reset();
        a = 20 + $urandom_range(15);
        b = a + 10 + $urandom_range(20);
        wr(1, 16'(a));
        wr(2, 16'(b));
        cyc(2);
        {one_pulse_select, pwm_select} <= 2'b11;
        high_len(n);
        chk(16'(n), 16'(2 * (b - a)));
        chk(counter_value, COUNT_PRESET);
        chk({capture_one_flag, compare_one_flag, compare_two_flag}, 16'h0004);
        wr(1, 16'(a + 5));
        high_len(n);
        chk(16'(n), 16'(2 * (b - a)));
        high_len(n);
        chk(16'(n), 16'(2 * (b - a - 5)));
        cap = capture_one_value;
        u_pulse_source.pulse(1, 2);
        u_pulse_source.pulse(2, 2);
        cyc(6);
        chk(capture_one_value, cap);
        chk(capture_two_flag, 1'b1);
        during_pulse_level <= 1'b1;
        cyc(3);
        v = 0;
        repeat (160) begin
            cyc(1);
            if (load_level !== 1'b1) v++;
        end
        chk(16'(v), 16'h0000);
        compare_one_pin_enable <= 1'b0;
        cyc(2);
        chk({compare_one_pin_oe, compare_one_pin, load_level}, 16'h0002);
        $display("pwm test done");
        // shared interrupt and wait wake
        capture_irq_enable <= 1'b1;
        cyc(3);
        chk(timer_irq, 1'b0);
        global_mask <= 1'b0;
        cyc(3);
        chk(timer_irq, 1'b1);
        {capture_irq_enable, compare_irq_enable} <= 2'b01;
        cyc(3);
        chk(timer_irq, 1'b0);
        {compare_irq_enable, overflow_irq_enable} <= 2'b01;
        wait_state <= 1'b1;
        cyc(3);
        chk({timer_irq, wait_wake}, 16'h0003);
        {wait_state, overflow_irq_enable} <= 2'b00;
        $display("interrupt test done");
        // halt: frozen counter, armed capture taken at wake
        strobe(0, 8'h00);
        strobe(2, 8'h00);
        cyc(2);
        chk(capture_two_flag, 1'b0);
        halt_state <= 1'b1;
        cyc(2);
        c0 = counter_value;
        cyc(16);
        chk(counter_value, c0);
        u_pulse_source.pulse(2, 2);
        cyc(5);
        chk(capture_two_flag, 1'b0);
        @(posedge mclk);
        halt_state <= 1'b0;
        halt_wake_irq <= 1'b1;
        @(posedge mclk);
        halt_wake_irq <= 1'b0;
        cyc(2);
        chk(capture_two_flag, 1'b1);
        chk(capture_two_value - c0 <= 16'h0001, 1'b1);
        $display("halt test done");
        stop_test();
    end
endmodule : tb_top
